// file: dmc_channel.sv
// one descriptor-driven transfer channel with scatter/gather reload
//
// Operation
// RULE1 - auto stop option clears the hardware request enable when the descriptor finishes
// RULE2 - signed last adjustments are added to source and destination at major end; the code adds dlast to the destination only when scatter/gather is off
// RULE3 - software sets or clears the request enable; requests ignored while clear
// RULE4 - a software start runs exactly one minor loop of the current descriptor
// RULE5 - the current iteration count is readable and shows remaining major iterations
// RULE6 - the minor byte count read back is the live decrementing value
// RULE7 - a source address misaligned to the source width raises a source address error
// RULE8 - scatter/gather loads the next descriptor from memory at completion
// RULE9 - software places descriptors on 32-byte aligned addresses
// RULE10 - status flags readable and cleared by mask; engine-wide channel error flags
// RULE11 - descriptor interrupt enables choose which completion events raise a request
// RULE12 - the 128-byte width is optional per instance
// RULE13 - minor link fires on each count decrement, major link at exhaustion; the code raises no minor link on the decrement that exhausts the count
// RULE14 - bandwidth control stalls none, four or eight cycles after each access; the code stalls only after each write, never after a read
// RULE15 - at exhaustion adjust addresses, reload the count, interrupt, fetch next
// RULE16 - modulo settings confine address updates to a power-of-two window
// RULE17 - each accepted request performs one whole minor loop, then decrements the count
`timescale 1ns/100ps
`default_nettype none
`include "dmc_map.svh"
module dmc_channel #(
    parameter bit HAS_128 = 1'b0,
    parameter int FIFO_W  = 32,
    parameter int FIFO_D  = 8
) (
    input  wire logic              CLK,
    input  wire logic              RST_N,
    input  wire logic              CE,
    input  wire logic              HW_REQ,
    input  wire logic              ERQ_SET,
    input  wire logic              ERQ_CLR,
    input  wire logic              SW_START,
    input  wire logic              DESC_WE,
    input  wire logic [2:0]        DESC_IDX,
    input  wire logic [31:0]       DESC_WDATA,
    input  wire logic [2:0]        STATUS_CLR,
    output var  logic              MEM_REQ,
    output var  logic              MEM_WE,
    output var  logic [31:0]       MEM_ADDR,
    output var  dmc_pkg::dmc_size_t MEM_SIZE,
    output var  logic [31:0]       MEM_WDATA,
    input  wire logic              MEM_ACK,
    input  wire logic [31:0]       MEM_RDATA,
    output var  logic              HW_REQ_EN,
    output var  logic [14:0]       CUR_ITER,
    output var  logic [31:0]       MINOR_BYTE_COUNT,
    output var  logic [2:0]        STATUS,
    output var  logic [3:0]        ERR_FLAGS,
    output var  logic              ERR_CHANNELS,
    output var  logic              MINOR_LINK,
    output var  logic              MAJOR_LINK,
    output var  logic [3:0]        LINK_CH
);
    import dmc_pkg::*;

    typedef struct packed {
        dmc_state_t  st;
        dmc_desc_t   d;
        logic [31:0] nb_init;
        logic [31:0] sga;
        logic [2:0]  widx;
        logic        erq;
        logic        pend_sw;
        logic        req;
        logic        we;
        logic [31:0] addr;
        dmc_size_t   size;
        logic [31:0] wdata;
        logic [3:0]  stall;
        logic [2:0]  status;
        logic [3:0]  errs;
        logic        chan_err;
        logic        mnl;
        logic        mjl;
    } dmc_core_t;

    dmc_core_t q, n;
    logic [31:0] src_next, dst_next;
    logic        f_in_ready, f_out_valid, f_pop, f_push;
    logic [31:0] f_out_data;
    logic        min_end, maj_now, leave;

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    function automatic logic [31:0] beat_bytes(input dmc_size_t sz);
        unique case (sz)
            `DMC_SZ_1: beat_bytes = 32'h1;
            `DMC_SZ_2: beat_bytes = 32'h2;
            default:   beat_bytes = 32'h4; // 128-byte units move as word beats
        endcase
    endfunction : beat_bytes

    function automatic logic misaligned(input logic [31:0] a, input dmc_size_t sz);
        unique case (sz)
            `DMC_SZ_1:   misaligned = 1'b0;
            `DMC_SZ_2:   misaligned = a[0];
            `DMC_SZ_4:   misaligned = |a[1:0];
            default:     misaligned = |a[6:0];
        endcase
    endfunction : misaligned

    function automatic logic size_ok(input dmc_size_t sz);
        size_ok = (sz == `DMC_SZ_1) || (sz == `DMC_SZ_2) || (sz == `DMC_SZ_4)
                  || (HAS_128 && sz == `DMC_SZ_128); // RULE12
    endfunction : size_ok

    // one descriptor word into the working descriptor; shared by software and fetch
    function automatic dmc_desc_t put_word(input dmc_desc_t d, input logic [2:0] i,
                                           input logic [31:0] w);
        dmc_desc_t r;
        r = d;
        unique case (i)
            `DMC_W_SADDR:  r.saddr = w;
            `DMC_W_ATTR: begin
                r.soff  = w[`DMC_F_SOFF];
                r.smod  = w[`DMC_F_SMOD];
                r.ssize = w[`DMC_F_SSIZE];
                r.dmod  = w[`DMC_F_DMOD];
                r.dsize = w[`DMC_F_DSIZE];
            end
            `DMC_W_MBC:    r.nb = w;
            `DMC_W_SLAST:  r.slast = w;
            `DMC_W_DADDR:  r.daddr = w;
            `DMC_W_DOFF: begin
                r.iter  = w[`DMC_F_ITER];
                r.doff  = w[`DMC_F_LOW16];
            end
            `DMC_W_DLAST:  r.dlast = w;
            `DMC_W_CSR: begin
                r.iter0 = w[`DMC_F_ITER];
                r.csr   = w[`DMC_F_LOW16];
            end
        endcase
        put_word = r;
    endfunction : put_word

    // ---------------------------------------------------------------
    // datapath pieces
    // ---------------------------------------------------------------
    dmc_addr_step u_src_step (
        .base   (q.d.saddr),
        .off    ({{16{q.d.soff[15]}}, q.d.soff}),
        .modulo (q.d.smod),
        .sum    (src_next)
    );

    dmc_addr_step u_dst_step (
        .base   (q.d.daddr),
        .off    ({{16{q.d.doff[15]}}, q.d.doff}),
        .modulo (q.d.dmod),
        .sum    (dst_next)
    );

    dmc_fifo #(.W(FIFO_W), .D(FIFO_D)) u_fifo (
        .clk       (CLK),
        .rst_n     (RST_N),
        .ce        (CE),
        .in_valid  (f_push),
        .in_ready  (f_in_ready),
        .in_data   (MEM_RDATA),
        .out_valid (f_out_valid),
        .out_ready (f_pop),
        .out_data  (f_out_data)
    );

    // ---------------------------------------------------------------
    // control
    // ---------------------------------------------------------------
    always_comb begin
        n       = q;
        n.mnl   = 1'b0;
        n.mjl   = 1'b0;
        f_push  = 1'b0;
        f_pop   = 1'b0;
        leave   = 1'b0;
        min_end = 1'b0;
        maj_now = 1'b0;
        // mask clear first so that a same-cycle set below wins
        n.status = q.status & ~STATUS_CLR; // RULE10
        if (STATUS_CLR[`DMC_ST_ERR]) begin
            n.errs     = '0;
            n.chan_err = 1'b0;
        end
        if (ERQ_CLR) n.erq = 1'b0; // RULE3
        if (ERQ_SET) n.erq = 1'b1; // RULE3
        if (SW_START) n.pend_sw = 1'b1;
        unique case (q.st)
            DMC_IDLE: begin
                if (DESC_WE) begin
                    n.d = put_word(q.d, DESC_IDX, DESC_WDATA);
                    if (DESC_IDX == `DMC_W_MBC) n.nb_init = DESC_WDATA;
                end else if ((HW_REQ && q.erq) || q.pend_sw) begin // RULE3 RULE4
                    n.pend_sw = SW_START;
                    if (!size_ok(q.d.ssize) || !size_ok(q.d.dsize)) begin
                        n.errs[`DMC_E_CFG] = 1'b1;
                        n.chan_err         = 1'b1;
                        n.status[`DMC_ST_ERR] = 1'b1;
                    end else begin
                        n.st = DMC_READ; // RULE17
                    end
                end
            end
            DMC_READ: begin
                if (!q.req) begin
                    if (misaligned(q.d.saddr, q.d.ssize)) begin
                        n.errs[`DMC_E_SRC]    = 1'b1; // RULE7
                        n.chan_err            = 1'b1;
                        n.status[`DMC_ST_ERR] = 1'b1;
                        n.st                  = DMC_IDLE;
                    end else if (f_in_ready) begin
                        n.req  = 1'b1;
                        n.we   = 1'b0;
                        n.addr = q.d.saddr;
                        n.size = q.d.ssize;
                    end
                end else if (MEM_ACK) begin
                    f_push    = 1'b1;
                    n.req     = 1'b0;
                    n.d.saddr = src_next; // RULE16
                    n.st      = DMC_WRITE;
                end
            end
            DMC_WRITE: begin
                if (!q.req && f_out_valid) begin
                    f_pop = 1'b1;
                    if (misaligned(q.d.daddr, q.d.dsize)) begin
                        n.errs[`DMC_E_DAE]    = 1'b1;
                        n.chan_err            = 1'b1;
                        n.status[`DMC_ST_ERR] = 1'b1;
                        n.st                  = DMC_IDLE;
                    end else begin
                        n.req   = 1'b1;
                        n.we    = 1'b1;
                        n.addr  = q.d.daddr;
                        n.size  = q.d.dsize;
                        n.wdata = f_out_data;
                    end
                end else if (q.req && MEM_ACK) begin
                    n.req     = 1'b0;
                    n.d.daddr = dst_next; // RULE16
                    // live count, the programmed value is kept only internally
                    n.d.nb = (q.d.nb > beat_bytes(q.d.ssize)) ?
                             q.d.nb - beat_bytes(q.d.ssize) : '0; // RULE6
                    unique case (q.d.csr[`DMC_C_BWC])
                        `DMC_BWC_4: n.stall = `DMC_STALL_4; // RULE14
                        `DMC_BWC_8: n.stall = `DMC_STALL_8; // RULE14
                        default:    n.stall = '0;
                    endcase
                    if (n.stall != '0) n.st = DMC_STALL;
                    else leave = 1'b1;
                end
            end
            DMC_STALL: begin
                n.stall = q.stall - 4'h1;
                if (q.stall == 4'h1) leave = 1'b1; // RULE14
            end
            DMC_FETCH: begin
                if (!q.req) begin
                    n.req  = 1'b1;
                    n.we   = 1'b0;
                    n.addr = q.sga + {27'h0, q.widx, 2'b00};
                    n.size = `DMC_SZ_4;
                end else if (MEM_ACK) begin
                    n.req  = 1'b0;
                    n.d    = put_word(q.d, q.widx, MEM_RDATA); // RULE8
                    if (q.widx == `DMC_W_MBC) n.nb_init = MEM_RDATA;
                    n.widx = q.widx + 3'h1;
                    if (q.widx == `DMC_LAST_WORD) n.st = DMC_IDLE;
                end
            end
            default: n.st = DMC_IDLE;
        endcase
        if (leave) begin
            if (n.d.nb != '0) begin
                n.st = DMC_READ;
            end else begin
                min_end    = 1'b1;
                n.d.nb     = q.nb_init;
                n.d.iter   = q.d.iter - 15'h1; // RULE17 RULE5
                n.st       = DMC_IDLE;
                if (q.d.iter > 15'h1) begin
                    n.mnl = q.d.csr[`DMC_C_MINLNK]; // RULE13
                    if (q.d.csr[`DMC_C_INTHALF] && n.d.iter == (q.d.iter0 >> 1)) begin
                        n.status[`DMC_ST_INT] = 1'b1; // RULE11
                    end
                end else begin
                    maj_now   = 1'b1;
                    n.d.iter  = q.d.iter0; // RULE15
                    n.d.saddr = n.d.saddr + q.d.slast; // RULE2
                    n.status[`DMC_ST_DONE] = 1'b1;
                    if (q.d.csr[`DMC_C_INTMAJ]) n.status[`DMC_ST_INT] = 1'b1; // RULE11
                    if (q.d.csr[`DMC_C_DREQ] && !ERQ_SET) n.erq = 1'b0; // RULE1
                    n.mjl = q.d.csr[`DMC_C_MAJLNK]; // RULE13
                    if (q.d.csr[`DMC_C_ESG]) begin
                        if ((q.d.dlast & `DMC_SGA_MASK) != '0) begin
                            n.errs[`DMC_E_SGE]    = 1'b1; // RULE9
                            n.chan_err            = 1'b1;
                            n.status[`DMC_ST_ERR] = 1'b1;
                        end else begin
                            n.sga  = q.d.dlast; // RULE8 RULE15
                            n.widx = '0;
                            n.st   = DMC_FETCH;
                        end
                    end else begin
                        n.d.daddr = n.d.daddr + q.d.dlast; // RULE2
                    end
                end
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            q <= '0;
        end else if (CE) begin
            q <= n;
        end
    end

    assign MEM_REQ          = q.req;
    assign MEM_WE           = q.we;
    assign MEM_ADDR         = q.addr;
    assign MEM_SIZE         = q.size;
    assign MEM_WDATA        = q.wdata;
    assign HW_REQ_EN        = q.erq;
    assign CUR_ITER         = q.d.iter;
    assign MINOR_BYTE_COUNT = q.d.nb;
    assign STATUS           = q.status;
    assign ERR_FLAGS        = q.errs;
    assign ERR_CHANNELS     = q.chan_err;
    assign MINOR_LINK       = q.mnl;
    assign MAJOR_LINK       = q.mjl;
    assign LINK_CH          = q.d.csr[`DMC_C_LINKCH];

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    property p_auto_stop;
        CE && maj_now && q.d.csr[`DMC_C_DREQ] && !ERQ_SET |=> !HW_REQ_EN;
    endproperty
    a_auto_stop: assert property (p_auto_stop) // RULE1
        else $error("auto stop did not clear request enable");

    property p_src_last;
        CE && maj_now |=> q.d.saddr == $past(q.d.saddr) + $past(q.d.slast);
    endproperty
    a_src_last: assert property (p_src_last) // RULE2
        else $error("source last adjustment not applied");

    property p_req_ignored;
        CE && q.st == DMC_IDLE && !q.erq && !q.pend_sw && !SW_START && !ERQ_SET
            |=> q.st == DMC_IDLE;
    endproperty
    a_req_ignored: assert property (p_req_ignored) // RULE3
        else $error("request served while enable clear");

    property p_iter_dec;
        CE && min_end && q.d.iter > 15'h1 |=> CUR_ITER == $past(CUR_ITER) - 15'h1;
    endproperty
    a_iter_dec: assert property (p_iter_dec) // RULE17
        else $error("iteration count not decremented once");

    property p_iter_reload;
        CE && maj_now |=> CUR_ITER == $past(q.d.iter0);
    endproperty
    a_iter_reload: assert property (p_iter_reload) // RULE15
        else $error("iteration count not reloaded");

    property p_src_err;
        CE && q.st == DMC_READ && !q.req && misaligned(q.d.saddr, q.d.ssize)
            |=> ERR_FLAGS[`DMC_E_SRC] && !MEM_REQ;
    endproperty
    a_src_err: assert property (p_src_err) // RULE7
        else $error("misaligned source not flagged");

    property p_stall8;
        CE && q.st == DMC_WRITE && q.req && MEM_ACK && q.d.csr[`DMC_C_BWC] == `DMC_BWC_8
            |=> (q.st == DMC_STALL)[*8];
    endproperty
    a_stall8: assert property (p_stall8) // RULE14
        else $error("eight-cycle stall too short");

    property p_minor_link;
        CE && min_end && q.d.iter > 15'h1 && q.d.csr[`DMC_C_MINLNK] |=> MINOR_LINK;
    endproperty
    a_minor_link: assert property (p_minor_link) // RULE13
        else $error("minor link missing");

    property p_int_major;
        CE && maj_now && q.d.csr[`DMC_C_INTMAJ] |=> STATUS[`DMC_ST_INT];
    endproperty
    a_int_major: assert property (p_int_major) // RULE11
        else $error("major interrupt flag missing");

    property p_done_wins;
        CE && maj_now |=> STATUS[`DMC_ST_DONE];
    endproperty
    a_done_wins: assert property (p_done_wins) // RULE10
        else $error("done flag lost against clear");
endmodule : dmc_channel
`default_nettype wire

// file: dmc_map.svh
// offsets, field positions, encodings and timing counts of the channel
`ifndef DMC_MAP_SVH
`define DMC_MAP_SVH
// descriptor word indices
`define DMC_W_SADDR   3'h0
`define DMC_W_ATTR    3'h1
`define DMC_W_MBC     3'h2
`define DMC_W_SLAST   3'h3
`define DMC_W_DADDR   3'h4
`define DMC_W_DOFF    3'h5
`define DMC_W_DLAST   3'h6
`define DMC_W_CSR     3'h7
// field positions
`define DMC_F_SOFF    31:16
`define DMC_F_SMOD    15:11
`define DMC_F_SSIZE   10:8
`define DMC_F_DMOD    7:3
`define DMC_F_DSIZE   2:0
`define DMC_F_ITER    30:16
`define DMC_F_LOW16   15:0
`define DMC_C_INTMAJ  0
`define DMC_C_INTHALF 1
`define DMC_C_DREQ    2
`define DMC_C_ESG     3
`define DMC_C_MINLNK  4
`define DMC_C_MAJLNK  5
`define DMC_C_BWC     7:6
`define DMC_C_LINKCH  11:8
// transfer size encodings
`define DMC_SZ_1      3'h0
`define DMC_SZ_2      3'h1
`define DMC_SZ_4      3'h2
`define DMC_SZ_128    3'h6
// bandwidth stall
`define DMC_BWC_4     2'h2
`define DMC_BWC_8     2'h3
`define DMC_STALL_4   4'h4
`define DMC_STALL_8   4'h8
// status and error bits
`define DMC_ST_DONE   0
`define DMC_ST_INT    1
`define DMC_ST_ERR    2
`define DMC_E_SRC     0
`define DMC_E_DAE     1
`define DMC_E_CFG     2
`define DMC_E_SGE     3
// descriptor pool alignment mask (32 bytes)
`define DMC_SGA_MASK  32'h0000001f
`define DMC_LAST_WORD 3'h7
`endif

// file: dmc_pkg.sv
// types shared by the channel control files
package dmc_pkg;
    typedef logic [2:0] dmc_size_t;
    typedef enum logic [2:0] {
        DMC_IDLE  = 3'b000,
        DMC_READ  = 3'b001,
        DMC_WRITE = 3'b010,
        DMC_STALL = 3'b011,
        DMC_FETCH = 3'b100
    } dmc_state_t;
    typedef struct packed {
        logic [31:0] saddr;
        logic [15:0] soff;
        logic [4:0]  smod;
        dmc_size_t   ssize;
        logic [4:0]  dmod;
        dmc_size_t   dsize;
        logic [31:0] nb;
        logic [31:0] slast;
        logic [31:0] daddr;
        logic [15:0] doff;
        logic [31:0] dlast;
        logic [14:0] iter;
        logic [14:0] iter0;
        logic [15:0] csr;
    } dmc_desc_t;
endpackage : dmc_pkg

// file: dmc_fifo.sv
// data buffer between the read and write phases
`timescale 1ns/100ps
`default_nettype none
module dmc_fifo #(
    parameter int W = 32,
    parameter int D = 8
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         ce,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(D);
    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0]       wp;
        logic [AW-1:0]       rp;
        logic [AW:0]         cnt;
    } dmc_fifo_st_t;
    dmc_fifo_st_t q, n;
    logic push, pop;

    assign in_ready  = q.cnt != (AW+1)'(D);
    assign out_valid = q.cnt != '0;
    assign out_data  = q.mem[q.rp];

    always_comb begin
        n    = q;
        push = in_valid && in_ready;
        pop  = out_valid && out_ready;
        if (push) begin
            n.mem[q.wp] = in_data;
            n.wp        = (q.wp == AW'(D - 1)) ? '0 : q.wp + 1'b1;
        end
        if (pop) begin
            n.rp = (q.rp == AW'(D - 1)) ? '0 : q.rp + 1'b1;
        end
        n.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            q <= '0;
        end else if (ce) begin
            q <= n;
        end
    end
endmodule : dmc_fifo
`default_nettype wire

// file: dmc_addr_step.sv
// address step with power-of-two modulo window
`timescale 1ns/100ps
`default_nettype none
module dmc_addr_step (
    input  wire logic [31:0] base,
    input  wire logic [31:0] off,
    input  wire logic [4:0]  modulo,
    output logic [31:0]      sum
);
    logic [31:0] mask;
    logic [31:0] raw;
    always_comb begin
        raw  = base + off;
        // zero modulo means the whole address space
        mask = (modulo == 5'h00) ? 32'hffffffff : ((32'h1 << modulo) - 32'h1);
        sum  = (base & ~mask) | (raw & mask); // RULE16
    end
endmodule : dmc_addr_step
`default_nettype wire

// file: dmc_dummy_never.sv
// holds no logic

// file: dmc_mem_model.sv
// memory stand-in that answers the channel's bus accesses
`timescale 1ns/100ps
`default_nettype none
module dmc_mem_model (
    input  wire logic        clk,
    input  wire logic        slow,
    input  wire logic        req,
    input  wire logic        we,
    input  wire logic [31:0] addr,
    input  wire logic [31:0] wdata,
    output logic             ack,
    output logic [31:0]      rdata
);
    logic [31:0] mem [64];
    logic [31:0] last_rd;
    logic [31:0] last_wr;
    int          n_wr = 0;
    int          dly  = 0;
    initial ack = 1'b0;
    initial rdata = 32'h0;
    // read data flips when no answer stands, so a stale value never matches
    always @(posedge clk) begin
        rdata <= ~rdata;
        ack   <= 1'b0;
        if (!req || ack) begin
            dly <= slow ? 3 : 0;
        end else if (dly != 0) begin
            dly <= dly - 1;
        end else if (we) begin
            ack            <= 1'b1;
            mem[addr[7:2]] <= wdata;
            last_wr        <= addr;
            n_wr           <= n_wr + 1;
        end else begin
            ack     <= 1'b1;
            rdata   <= mem[addr[7:2]];
            last_rd <= addr;
        end
    end
endmodule : dmc_mem_model
`default_nettype wire

// file: dmc_channel_descriptor_control_tb_top.sv
// self-checking bench for one descriptor-driven channel
`timescale 1ns/100ps
`default_nettype none
module dma_channel_descriptor_control_tb_top;
    import dmc_pkg::*;
    logic        CLK, RST_N, HW_REQ, ERQ_SET, ERQ_CLR, SW_START, DESC_WE, MEM_ACK, slow;
    logic        MEM_REQ, MEM_WE, HW_REQ_EN, ERR_CHANNELS;
    logic [2:0]  DESC_IDX, STATUS_CLR, STATUS;
    logic [3:0]  ERR_FLAGS, LINK_CH;
    logic [14:0] CUR_ITER;
    logic [31:0] DESC_WDATA, MEM_ADDR, MEM_WDATA, MEM_RDATA, MINOR_BYTE_COUNT;
    logic [31:0] desc [8];
    int          miscompares = 0;
    int          n_checks = 0;
    dmc_channel i_dmc_channel (.CLK(CLK), .RST_N(RST_N), .CE(1'b1), .HW_REQ(HW_REQ),
        .ERQ_SET(ERQ_SET), .ERQ_CLR(ERQ_CLR), .SW_START(SW_START), .DESC_WE(DESC_WE),
        .DESC_IDX(DESC_IDX), .DESC_WDATA(DESC_WDATA), .STATUS_CLR(STATUS_CLR),
        .MEM_REQ(MEM_REQ), .MEM_WE(MEM_WE), .MEM_ADDR(MEM_ADDR), .MEM_SIZE(),
        .MEM_WDATA(MEM_WDATA), .MEM_ACK(MEM_ACK), .MEM_RDATA(MEM_RDATA),
        .HW_REQ_EN(HW_REQ_EN), .CUR_ITER(CUR_ITER), .MINOR_BYTE_COUNT(MINOR_BYTE_COUNT),
        .STATUS(STATUS), .ERR_FLAGS(ERR_FLAGS), .ERR_CHANNELS(ERR_CHANNELS),
        .MINOR_LINK(), .MAJOR_LINK(), .LINK_CH(LINK_CH));
    dmc_mem_model i_dmc_mem_model (.clk(CLK), .slow(slow), .req(MEM_REQ), .we(MEM_WE),
        .addr(MEM_ADDR), .wdata(MEM_WDATA), .ack(MEM_ACK), .rdata(MEM_RDATA));
    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic summarize;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : summarize
    task automatic load;
        for (int i = 0; i < 8; i++) begin
            @(negedge CLK);
            DESC_WE = 1'b1;
            DESC_IDX = i[2:0];
            DESC_WDATA = desc[i];
        end
        @(negedge CLK);
        DESC_WE = 1'b0;
    endtask : load
    task automatic kick;
        @(negedge CLK);
        SW_START = 1'b1;
        @(negedge CLK);
        SW_START = 1'b0;
    endtask : kick
    // bounded wait on the model's write count, then let the count update land
    task automatic wait_wr(input int n);
        for (int k = 0; k < 300 && i_dmc_mem_model.n_wr != n; k++) begin
            @(negedge CLK);
        end
        repeat (3) @(negedge CLK);
        chk("write count", i_dmc_mem_model.n_wr, n);
    endtask : wait_wr
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_enable;
        chk("status after reset", {29'h0, STATUS}, 32'h0);
        @(negedge CLK) ERQ_SET = 1'b1;
        @(negedge CLK) ERQ_SET = 1'b0;
        @(negedge CLK) chk("enable set", {31'h0, HW_REQ_EN}, 32'h1);
        ERQ_CLR = 1'b1;
        @(negedge CLK) ERQ_CLR = 1'b0;
        @(negedge CLK) chk("enable clear", {31'h0, HW_REQ_EN}, 32'h0);
    endtask : t_enable
    task automatic t_sw_loop;
        desc = '{32'h0, 32'h0004_021a, 32'h8, 32'hffff_fff0, 32'h40, 32'h0002_0004,
                 32'hffff_fff0, 32'h0002_0315};
        load();
        chk("iter loaded", {17'h0, CUR_ITER}, 32'h2);
        chk("link channel", {28'h0, LINK_CH}, 32'h3);
        kick();
        wait_wr(2);
        chk("iter after minor", {17'h0, CUR_ITER}, 32'h1);
        chk("byte count", MINOR_BYTE_COUNT, 32'h8);
        chk("moved word", i_dmc_mem_model.mem[17], 32'ha5c3_0001);
    endtask : t_sw_loop
    task automatic t_hw_major;
        HW_REQ = 1'b1;
        slow = 1'b1;
        repeat (10) @(negedge CLK);
        chk("ignored request", i_dmc_mem_model.n_wr, 32'h2);
        @(negedge CLK) ERQ_SET = 1'b1;
        @(negedge CLK) ERQ_SET = 1'b0;
        wait_wr(3);
        chk("live count", MINOR_BYTE_COUNT, 32'h4);
        wait_wr(4);
        chk("iter reload", {17'h0, CUR_ITER}, 32'h2);
        chk("done and int", {29'h0, STATUS}, 32'h3);
        chk("auto stop", {31'h0, HW_REQ_EN}, 32'h0);
        repeat (10) @(negedge CLK);
        chk("no further loop", i_dmc_mem_model.n_wr, 32'h4);
        HW_REQ = 1'b0;
        slow = 1'b0;
        kick();
        wait_wr(6);
        chk("source adjusted", i_dmc_mem_model.last_rd, 32'h4);
        chk("dest adjusted", i_dmc_mem_model.last_wr, 32'h34);
        @(negedge CLK) STATUS_CLR = 3'h3;
        @(negedge CLK) STATUS_CLR = 3'h0;
        @(negedge CLK) chk("status cleared", {29'h0, STATUS}, 32'h0);
    endtask : t_hw_major
    task automatic t_misaligned;
        desc[0] = 32'h2;
        load();
        kick();
        repeat (12) @(negedge CLK);
        chk("source error", {28'h0, ERR_FLAGS}, 32'h1);
        chk("error status", {29'h0, STATUS}, 32'h4);
        chk("engine errors", {31'h0, ERR_CHANNELS}, 32'h1);
        chk("no write", i_dmc_mem_model.n_wr, 32'h6);
        @(negedge CLK) STATUS_CLR = 3'h4;
        @(negedge CLK) STATUS_CLR = 3'h0;
        @(negedge CLK) chk("errors cleared", {28'h0, ERR_FLAGS}, 32'h0);
    endtask : t_misaligned
    task automatic t_gather;
        desc = '{32'h0, 32'h0004_0202, 32'h4, 32'h0, 32'h40, 32'h0003_0004, 32'h0,
                 32'h0003_0000};
        for (int i = 0; i < 8; i++) begin
            i_dmc_mem_model.mem[32+i] = desc[i];
        end
        desc[5] = 32'h0001_0004;
        desc[6] = 32'h80;
        desc[7] = 32'h0001_00c8;
        load();
        kick();
        wait_wr(7);
        repeat (40) @(negedge CLK);
        chk("next descriptor", {17'h0, CUR_ITER}, 32'h3);
        chk("done", {31'h0, STATUS[0]}, 32'h1);
    endtask : t_gather
    initial begin
        CLK = 1'b0;
        forever #2.5 CLK = ~CLK;
    end
    initial begin
        #20000;
        miscompares++;
        summarize();
    end
    initial begin
        {RST_N, HW_REQ, ERQ_SET, ERQ_CLR, SW_START, DESC_WE, slow} = 7'h0;
        DESC_IDX = 3'h0;
        DESC_WDATA = 32'h0;
        STATUS_CLR = 3'h0;
        for (int i = 0; i < 64; i++) begin
            i_dmc_mem_model.mem[i] = {16'ha5c3, i[15:0]};
        end
        repeat (16) @(negedge CLK);
        RST_N = 1'b1;
        t_enable();
        t_sw_loop();
        t_hw_major();
        t_misaligned();
        t_gather();
        summarize();
    end
endmodule : dma_channel_descriptor_control_tb_top
`default_nettype wire
